// *** rtl/crl_counter_readback_latch.sv ***
// Count latch, readback and byte sequencing for three down-counters
`timescale 1ns/1ps
`default_nettype none
module crl_counter_readback_latch import crl_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] ioAddr,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  output logic ioRdValid,
  input wire logic [NUM_CNT-1:0][CNT_W-1:0] liveCount,
  input wire logic [NUM_CNT-1:0] coreOut,
  input wire logic [NUM_CNT-1:0] coreLoadTaken,
  input wire logic [NUM_CNT-1:0] gatePin,
  output logic [NUM_CNT-1:0][CNT_W-1:0] loadValue,
  output logic [NUM_CNT-1:0] loadStrobe,
  output logic [NUM_CNT-1:0] countRun,
  output logic [NUM_CNT-1:0] nullCount,
  output crl_ctrl_s [NUM_CNT-1:0] ctrlOut
);

  // Bus strobes; with ce low the block ignores the host as well as freezing
  wire rdStrobe = ce && ioRd;
  wire wrStrobe = ce && ioWr;

  // Address compare shared by the control and all data locations
  function automatic logic addrIs(input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction

  // Byte of a 16-bit value picked by one read step
  function automatic logic [7:0] byteOf(input logic [CNT_W-1:0] value, input logic upper);
    return upper ? value[CNT_W-1:8] : value[7:0];
  endfunction

  // New count word for the access type; the byte not written loads as zero
  function automatic logic [CNT_W-1:0] assembleLoad(input logic [1:0] accessType,
                                                    input logic [7:0] data,
                                                    input logic [7:0] lowByte);
    logic [CNT_W-1:0] word;
    unique case (accessType)
      RW_HI_ONLY: word = {data, BYTE_RST};
      RW_LO_HI: word = {data, lowByte};
      default: word = {BYTE_RST, data};
    endcase
    return word;
  endfunction

  // Control location decode shared by all counters
  wire ctlWr = wrStrobe && addrIs(ioAddr, OFS_CTRL);
  wire [1:0] pickField = ioWrData[B_PICK_HI:B_PICK_LO];
  wire isReadback = (pickField == PICK_READBACK);
  wire [1:0] rwField = ioWrData[B_RW_HI:B_RW_LO];
  wire latchCountN = ioWrData[B_LATCH_COUNT_N];
  wire latchStateN = ioWrData[B_LATCH_STATE_N];
  wire crl_ctrl_s newCtrl = '{accessType: rwField,
                              mode: ioWrData[B_MODE_HI:B_MODE_LO],
                              bcd: ioWrData[B_BCD]};

  logic [NUM_CNT-1:0][7:0] rdByte;
  logic [NUM_CNT-1:0] rdHit;

  for (genvar g = 0; g < NUM_CNT; g++) begin : gCnt
    localparam logic [1:0] PICK_ME = 2'(g);
    localparam logic [ADDR_W-1:0] OFS_ME = OFS_DATA0 + ADDR_W'(g);

    // Programming state
    crl_ctrl_s ctrl_r;
    logic rdTog_r;
    logic wrTog_r;

    // Latched count and status
    logic [CNT_W-1:0] hold_r;
    logic [7:0] status_r;
    logic cntLat_r;
    logic staLat_r;

    // Load path towards the core
    logic [CNT_W-1:0] load_r;
    logic [7:0] lowTmp_r;
    logic loadStb_r;
    logic null_r;

    // Gate synchroniser
    logic gateMeta_r;
    logic gateSync_r;

    // Command decode for this counter
    wire progHit = ctlWr && !isReadback && (pickField == PICK_ME);
    wire latchCmd = progHit && (rwField == RW_LATCH);
    wire progCmd = progHit && (rwField != RW_LATCH);
    wire rbPicked = ctlWr && isReadback && ioWrData[B_SEL_LSB + g];
    wire rbCount = rbPicked && !latchCountN;
    wire rbState = rbPicked && !latchStateN;
    wire countLatchReq = (latchCmd || rbCount) && !cntLat_r;
    wire stateLatchReq = rbState && !staLat_r;

    // Data location access
    wire hitRd = rdStrobe && addrIs(ioAddr, OFS_ME);
    wire hitWr = wrStrobe && addrIs(ioAddr, OFS_ME);
    wire twoByte = (ctrl_r.accessType == RW_LO_HI);
    wire highSel = (ctrl_r.accessType == RW_HI_ONLY) || (twoByte && rdTog_r);
    // Live count is only the core's transferred value, so a pending load stays hidden
    wire [CNT_W-1:0] srcVal = cntLat_r ? hold_r : liveCount[g];
    wire countByteRd = hitRd && !staLat_r;
    wire countDone = countByteRd && (!twoByte || rdTog_r);
    wire wrFirst = hitWr && twoByte && !wrTog_r;
    wire wrDone = hitWr && !wrFirst;
    wire [7:0] statusNew = {coreOut[g], null_r, ctrl_r.accessType, ctrl_r.mode,
                            ctrl_r.bcd};

    assign rdHit[g] = hitRd;
    assign rdByte[g] = staLat_r ? status_r : byteOf(srcVal, highSel);

    // Access type and mode, replaced by every programming command
    wire crl_ctrl_s ctrl_nxt = progCmd ? newCtrl : ctrl_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        ctrl_r <= CTRL_RST;
      end else if (ce) begin
        ctrl_r <= ctrl_nxt;
      end
    end

    // Read toggle: a status read leaves it alone so count pairs stay aligned
    wire rdTog_nxt = progCmd ? 1'b0 : (rdTog_r ^ (countByteRd && twoByte));
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        rdTog_r <= 1'b0;
      end else if (ce) begin
        rdTog_r <= rdTog_nxt;
      end
    end

    // Write toggle: set by the low byte, cleared by the byte that completes a load
    wire wrTog_nxt = progCmd ? 1'b0 : (wrFirst || (wrTog_r && !wrDone));
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        wrTog_r <= 1'b0;
      end else if (ce) begin
        wrTog_r <= wrTog_nxt;
      end
    end

    // Count hold register: snapshot without stopping the core
    wire [CNT_W-1:0] hold_nxt = countLatchReq ? liveCount[g] : hold_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        hold_r <= COUNT_RST;
      end else if (ce) begin
        hold_r <= hold_nxt;
      end
    end

    // Latch flag blocks further count latches until the held count is read out
    wire cntLat_nxt = progCmd ? 1'b0 : (countLatchReq || (cntLat_r && !countDone));
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        cntLat_r <= 1'b0;
      end else if (ce) begin
        cntLat_r <= cntLat_nxt;
      end
    end

    // Status capture takes the first read ahead of any held count
    wire [7:0] status_nxt = stateLatchReq ? statusNew : status_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        status_r <= BYTE_RST;
      end else if (ce) begin
        status_r <= status_nxt;
      end
    end

    // A status read releases the status, so the held count follows it
    wire staLat_nxt = progCmd ? 1'b0 : (stateLatchReq || (staLat_r && !hitRd));
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        staLat_r <= 1'b0;
      end else if (ce) begin
        staLat_r <= staLat_nxt;
      end
    end

    // Low byte waits here until its high byte completes the pair
    wire [7:0] lowTmp_nxt = wrFirst ? ioWrData : lowTmp_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        lowTmp_r <= BYTE_RST;
      end else if (ce) begin
        lowTmp_r <= lowTmp_nxt;
      end
    end

    // New count handed to the core with a one-cycle strobe
    wire [CNT_W-1:0] loadWord = assembleLoad(ctrl_r.accessType, ioWrData, lowTmp_r);
    wire [CNT_W-1:0] load_nxt = wrDone ? loadWord : load_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        load_r <= COUNT_RST;
      end else if (ce) begin
        load_r <= load_nxt;
      end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        loadStb_r <= 1'b0;
      end else if (ce) begin
        loadStb_r <= wrDone;
      end
    end

    // A write in the same cycle as the core's transfer keeps the flag set
    wire null_nxt = wrDone || progCmd || (null_r && !coreLoadTaken[g]);
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        null_r <= 1'b0;
      end else if (ce) begin
        null_r <= null_nxt;
      end
    end

    // Gate pin crosses in through two flops; the core decrements only when high
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        gateMeta_r <= 1'b0;
      end else if (ce) begin
        gateMeta_r <= gatePin[g];
      end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        gateSync_r <= 1'b0;
      end else if (ce) begin
        gateSync_r <= gateMeta_r;
      end
    end

    assign ctrlOut[g] = ctrl_r;
    assign loadValue[g] = load_r;
    assign loadStrobe[g] = loadStb_r;
    assign nullCount[g] = null_r;
    assign countRun[g] = gateSync_r;
  end

  // Read data mux: at most one data location matches
  logic [7:0] rdSel;
  always_comb begin
    rdSel = BYTE_RST;
    for (int i = 0; i < NUM_CNT; i++) begin
      if (rdHit[i]) begin
        rdSel = rdByte[i];
      end
    end
  end

  // Unmapped reads give zero and no valid, so a stray address is visible
  wire [7:0] rdData_nxt = rdSel;
  wire rdValid_nxt = |rdHit;
  logic [7:0] rdData_r;
  logic rdValid_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_r <= BYTE_RST;
    end else if (ce) begin
      rdData_r <= rdData_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdValid_r <= 1'b0;
    end else if (ce) begin
      rdValid_r <= rdValid_nxt;
    end
  end

  assign ioRdData = rdData_r;
  assign ioRdValid = rdValid_r;

endmodule // crl_counter_readback_latch
`default_nettype wire

// *** rtl/crl_pkg.sv ***
// Shared constants and types for the counter latch and readback block
package crl_pkg;
  localparam int NUM_CNT = 3;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_DATA0 = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h1b;
  localparam int B_PICK_HI = 7;
  localparam int B_PICK_LO = 6;
  localparam int B_RW_HI = 5;
  localparam int B_RW_LO = 4;
  localparam int B_MODE_HI = 3;
  localparam int B_MODE_LO = 1;
  localparam int B_BCD = 0;
  localparam int B_LATCH_COUNT_N = 5;
  localparam int B_LATCH_STATE_N = 4;
  localparam int B_SEL_LSB = 1;
  localparam logic [1:0] PICK_READBACK = 2'h3;
  localparam logic [1:0] RW_LATCH = 2'h0;
  localparam logic [1:0] RW_LO_ONLY = 2'h1;
  localparam logic [1:0] RW_HI_ONLY = 2'h2;
  localparam logic [1:0] RW_LO_HI = 2'h3;

  typedef struct packed {
    logic [1:0] accessType;
    logic [2:0] mode;
    logic bcd;
  } crl_ctrl_s;

  localparam crl_ctrl_s CTRL_RST = '{accessType: 2'h3, mode: 3'h0, bcd: 1'b0};
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
endpackage

// *** tb/crl_core_model.sv ***
// Behavioural counting cores on the far side of the latch block
`timescale 1ns/1ps
`default_nettype none
module crl_core_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [2:0][15:0] loadValue,
  input wire logic [2:0] loadStrobe,
  input wire logic [2:0] countRun,
  output logic [2:0][15:0] cnt,
  output logic [2:0] coreOut,
  output logic [2:0] taken
);
  logic [2:0] pend_r;
  assign coreOut = {cnt[2][0], cnt[1][0], cnt[0][0]};
  // Transfer lags the load a cycle, so a pending count stays hidden meanwhile
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= '0;
      taken <= '0;
      cnt <= '0;
    end else begin
      pend_r <= loadStrobe;
      taken <= pend_r;
      for (int i = 0; i < 3; i++) cnt[i] <= pend_r[i] ? loadValue[i] : cnt[i] - 16'(countRun[i]);
    end
  end
endmodule // crl_core_model
`default_nettype wire

// *** tb/crl_counter_readback_latch_bench.sv ***
// Directed bench for the counter latch block
`timescale 1ns/1ps
`default_nettype none
module crl_counter_readback_latch_bench import crl_pkg::*;;
  logic sys_clk = 0, resetn = 0, ce = 1, ioWr = 0, ioRd = 0, ioRdValid;
  logic [4:0] ioAddr = 0;
  logic [7:0] ioWrData = 0, ioRdData;
  logic [2:0] gatePin = 0, coreOut, taken, loadStrobe, countRun, nullCount;
  logic [2:0][15:0] liveCount, loadValue, ex;
  crl_ctrl_s [2:0] ctrlOut;
  int err_count = 0, checks = 0, cyc = 0;
  crl_counter_readback_latch dut (.sys_clk, .resetn, .ce, .ioAddr, .ioWr, .ioRd, .ioWrData,
    .ioRdData, .ioRdValid, .liveCount, .coreOut, .coreLoadTaken(taken), .gatePin, .loadValue,
    .loadStrobe, .countRun, .nullCount, .ctrlOut);
  crl_core_model u_core (.sys_clk, .resetn, .loadValue, .loadStrobe, .countRun, .cnt(liveCount),
    .coreOut, .taken);
  initial forever #50 sys_clk = ~sys_clk;
  task automatic check(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run needs under a hundred cycles; anything near this ceiling is a hang
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      finish_test;
    end
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] b);
    @(negedge sys_clk);
    ioAddr = a;
    ioWrData = b;
    ioWr = 1;
    @(negedge sys_clk);
    ioWr = 0;
  endtask
  task automatic rd(input logic [4:0] a, input logic v, input logic [7:0] e);
    @(negedge sys_clk);
    ioAddr = a;
    ioRd = 1;
    @(negedge sys_clk);
    ioRd = 0;
    check("valid", ioRdValid, v);
    check("byte", ioRdData, e);
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    resetn = 1;
    check("ctrl", ctrlOut[0], CTRL_RST);
    wr(OFS_CTRL, 8'h30);
    wr(OFS_DATA0, 8'h34);
    wr(OFS_DATA0, 8'h12);
    check("load", loadValue[0], 16'h1234);
    check("null", nullCount[0], 1);
    check("strobe", loadStrobe, 3'h1);
    repeat (3) @(negedge sys_clk);
    check("taken", nullCount[0], 0);
    wr(OFS_CTRL, 8'h00);
    gatePin = 3'h7;
    repeat (4) @(negedge sys_clk);
    check("run", countRun[0], 1);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_DATA0, 1, 8'h34);
    rd(OFS_DATA0, 1, 8'h12);
    wr(OFS_CTRL, 8'h77);
    check("bcd", ctrlOut[1], 6'h37);
    gatePin = 0;
    repeat (4) @(negedge sys_clk);
    ex = liveCount;
    wr(OFS_CTRL, 8'hc4);
    rd(OFS_DATA0 + 5'h1, 1, {ex[1][0], 7'h77});
    rd(OFS_DATA0 + 5'h1, 1, ex[1][7:0]);
    rd(OFS_DATA0 + 5'h1, 1, ex[1][15:8]);
    // Counting resumes two cycles after the gate rises, so only the held values can match
    wr(OFS_CTRL, 8'hde);
    gatePin = 3'h7;
    for (int i = 0; i < 3; i++) begin
      rd(OFS_DATA0 + 5'(i), 1, ex[i][7:0]);
      rd(OFS_DATA0 + 5'(i), 1, ex[i][15:8]);
    end
    gatePin = 0;
    repeat (4) @(negedge sys_clk);
    ex = liveCount;
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, 8'he2);
    rd(OFS_DATA0, 1, {ex[0][0], 7'h30});
    rd(OFS_DATA0, 1, ex[0][7:0]);
    rd(OFS_DATA0, 1, ex[0][15:8]);
    wr(OFS_CTRL, 8'h10);
    wr(OFS_DATA0, 8'h5a);
    check("lo only", loadValue[0], 16'h005a);
    wr(OFS_CTRL, 8'h20);
    wr(OFS_DATA0, 8'ha5);
    check("hi only", loadValue[0], 16'ha500);
    repeat (3) @(negedge sys_clk);
    rd(OFS_DATA0, 1, 8'ha5);
    // Let the read answer drop before freezing, or the frozen valid would look stray
    @(negedge sys_clk);
    ce = 0;
    wr(OFS_CTRL, 8'h30);
    check("frozen", ctrlOut[0], 6'h20);
    ce = 1;
    rd(5'h00, 0, 8'h00);
    finish_test;
  end
endmodule // crl_counter_readback_latch_bench
`default_nettype wire

// *** tb/crl_properties.sv ***
// Port checker for the counter latch block
`timescale 1ns/1ps
`default_nettype none
module crl_checker import crl_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] ioAddr,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic ioRdValid,
  input wire logic [NUM_CNT-1:0] gatePin,
  input wire logic [NUM_CNT-1:0] loadStrobe,
  input wire logic [NUM_CNT-1:0] countRun,
  input wire logic [NUM_CNT-1:0] nullCount,
  input wire crl_ctrl_s [NUM_CNT-1:0] ctrlOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic dHit = ioAddr >= OFS_DATA0 && ioAddr < OFS_CTRL;
  wire logic cmdWr = ce && ioWr && ioAddr == OFS_CTRL;
  wire logic keep = ioWrData[7:6] == PICK_READBACK || ioWrData[5:4] == RW_LATCH;
  AST_RD_ANS: assert property (ce && ioRd && dHit |=> ioRdValid) else $error("no answer");
  AST_RD_IDLE: assert property (ce && !(ioRd && dHit) |=> !ioRdValid && ioRdData == 8'h00)
    else $error("stray answer");
  AST_RD_CAUSE: assert property (ioRdValid |-> $past(ce && ioRd && dHit))
    else $error("bad valid");
  AST_PROG: assert property (cmdWr && !keep |=> ctrlOut[$past(ioWrData[7:6])] ==
    $past(ioWrData[5:0]) && nullCount[$past(ioWrData[7:6])]) else $error("bad control");
  AST_CMD_KEEP: assert property (cmdWr && keep |=> $stable(ctrlOut)) else $error("ctrl moved");
  AST_NULL_LOAD: assert property ((nullCount & loadStrobe) == loadStrobe)
    else $error("null missing");
  AST_LOAD_CAUSE: assert property (|loadStrobe |-> $past(ce && ioWr && dHit))
    else $error("stray load");
  AST_GATE_SYNC: assert property ($past(resetn, 2) && $past(resetn, 3) && $past(ce)
    && $past(ce, 2) |-> countRun == $past(gatePin, 2)) else $error("gate lost");
endmodule // crl_checker
bind crl_counter_readback_latch crl_checker u_chk (.sys_clk, .resetn, .ce, .ioAddr, .ioWr,
  .ioRd, .ioWrData, .ioRdData, .ioRdValid, .gatePin, .loadStrobe, .countRun, .nullCount, .ctrlOut);
`default_nettype wire
